// File: hw/acdspi_core.sv
// serial control/status front end of a multi-output load driver with recovery cycling
// assumes host is a mode-0 spi master clocking far below clk_i; diag inputs are raw comparator levels
//
// Overview of operation
// - with recovery bit set, a tripped output is re-enabled after a timed interval
// - on/off ratio during recovery cycling selectable, 15% or 25%
// - recovery cycling repeats at 1.5 kHz or 3 kHz
// - recovery bit cleared while overload persists leaves the output disabled
// - mode 0: sample input on rising clock, change output on falling clock
// - every frame travels least significant bit first both ways
// - with chip select low and no clock yet, output shows fault summary
// - output driver off while chip select high, on while low
// - a frame runs from chip select falling to chip select rising
// - each rising clock in a frame shifts input into 24-bit register
// - chip select rising copies the shift register into the chosen input register
// - only frames of exactly 24 clocks are committed; others are dropped
// - first rising clock loads status into output shifter; falling clocks shift
// - bit 0 picks input register written and status register returned
// - bits 1 to 17 each control one driver function
// - first register bit 23 low means standby, high means active
// - bits 18 and 19 select the highside output for the current monitor
// - committed bit 22 clears all status bits at the frame's end
// - a set over-current flag disables its driver
// - without recovery, tripped driver stays off until host clears its flag
// - thermal shutdown flag turns every driver off until cleared
// - entering standby clears latched registers and turns outputs off
// - diagnostics must persist 32 us, open load 1 ms, before flagging
`timescale 1ns/1ps
module acdspi_core #(
  parameter logic [15:0] OL_FILT_CYCLES  = 16'(acdspi_pkg::OL_FILT_CYC),
  parameter logic [14:0] REC_SLOW_CYCLES = 15'(acdspi_pkg::REC_SLOW_CYC),
  parameter logic [14:0] REC_FAST_CYCLES = 15'(acdspi_pkg::REC_FAST_CYC)
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        spi_clk_i,
  input  wire logic        chip_select_low_i,
  input  wire logic        host_to_device_line_i,
  output logic             device_to_host_o,
  output logic             device_to_host_oe_o,
  input  wire logic [16:0] overcurrent_raw_i,
  input  wire logic [16:0] open_load_raw_i,
  input  wire logic        overvoltage_raw_i,
  input  wire logic        undervoltage_raw_i,
  input  wire logic        thermal_off_raw_i,
  input  wire logic        temp_warning_raw_i,
  output logic      [16:0] drv_en_o,
  output logic      [1:0]  current_image_sel_o,
  output logic             active_o,
  output logic             thermal_off_flag_o,
  output logic             frame_dropped_o
);
  localparam int NDRV = acdspi_pkg::NUM_DRV;
  localparam int FW   = acdspi_pkg::FRAME_BITS;
  localparam logic [acdspi_pkg::CNT_W-1:0] FULL_CNT = acdspi_pkg::CNT_W'(acdspi_pkg::FRAME_BITS);
  localparam logic [acdspi_pkg::FLT_W-1:0] FLT_LAST = acdspi_pkg::FLT_W'(acdspi_pkg::DIAG_FILT_CYC - 1);
  localparam logic [acdspi_pkg::OLF_W-1:0] OLF_LAST = OL_FILT_CYCLES - 16'h0001;
  localparam logic [14:0] ON_SLOW_LO = 15'(int'(REC_SLOW_CYCLES) * acdspi_pkg::DUTY_LOW_PCT / 100);
  localparam logic [14:0] ON_SLOW_HI = 15'(int'(REC_SLOW_CYCLES) * acdspi_pkg::DUTY_HIGH_PCT / 100);
  localparam logic [14:0] ON_FAST_LO = 15'(int'(REC_FAST_CYCLES) * acdspi_pkg::DUTY_LOW_PCT / 100);
  localparam logic [14:0] ON_FAST_HI = 15'(int'(REC_FAST_CYCLES) * acdspi_pkg::DUTY_HIGH_PCT / 100);

  typedef struct packed {
    logic                                      sck_d;
    logic                                      desel_d;
    logic [FW-1:0]                             in_sh;
    logic [acdspi_pkg::CNT_W-1:0]              bit_cnt;
    logic [FW-1:0]                             out_sh;
    logic                                      out_loaded;
    logic                                      dout;
    logic [FW-1:0]                             ctrl0;
    logic [FW-1:0]                             ctrl1;
    logic [NDRV-1:0]                           oc_flag;
    logic [NDRV-1:0]                           ol_flag;
    logic                                      ov_flag;
    logic                                      uv_flag;
    logic                                      thoff_flag;
    logic                                      tw_flag;
    logic [NDRV+3:0][acdspi_pkg::FLT_W-1:0]    flt;
    logic [NDRV-1:0][acdspi_pkg::OLF_W-1:0]    ol_flt;
    logic [acdspi_pkg::PER_W-1:0]              per_cnt;
    logic [NDRV-1:0]                           tripped;
    logic [NDRV-1:0]                           drv_en;
    logic                                      dropped;
  } acdspi_core_t;

  acdspi_core_t s_reg;
  acdspi_core_t s_next;

  logic [2:0]      pin_s;
  logic [2*NDRV+3:0] diag_s;
  logic            sck_s;
  logic            desel_s;
  logic            din_s;
  logic [FW-1:0]   status0;
  logic [FW-1:0]   status1;
  logic            fault;
  logic            push_valid;
  logic            push_ready;
  logic            pop_valid;
  logic            pop_ready;
  logic [FW-1:0]   pop_data;
  logic [14:0]     period;
  logic [14:0]     on_cnt;
  logic [NDRV+3:0] short_cond;

  // pins and raw diagnostics are all asynchronous to clk_i
  // select enters inverted so its flops reset to the deselected level, no false frame start
  acdspi_sync #(.W(3)) u_pin_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .async_i ({spi_clk_i, ~chip_select_low_i, host_to_device_line_i}),
    .sync_o  (pin_s)
  );

  acdspi_sync #(.W(2*NDRV+4)) u_diag_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .async_i ({temp_warning_raw_i, thermal_off_raw_i, undervoltage_raw_i, overvoltage_raw_i,
               open_load_raw_i, overcurrent_raw_i}),
    .sync_o  (diag_s)
  );

  assign sck_s      = pin_s[2];
  assign desel_s    = ~pin_s[1];
  assign din_s      = pin_s[0];
  assign short_cond = {diag_s[2*NDRV+3:2*NDRV], diag_s[NDRV-1:0]};

  // status images; fault bit is a plain or of bits 1..22, high means fault
  always_comb begin
    status0                                      = '0;
    status0[acdspi_pkg::DRV_LSB +: NDRV]         = s_reg.ol_flag;
    status0[acdspi_pkg::ST_TW]                   = s_reg.tw_flag;
    status0[acdspi_pkg::ST_THOFF]                = s_reg.thoff_flag;
    status0[acdspi_pkg::ST_UV]                   = s_reg.uv_flag;
    status0[acdspi_pkg::ST_OV]                   = s_reg.ov_flag;
    status0[acdspi_pkg::ST_ONE]                  = 1'b1;
    status1                                      = '0;
    status1[acdspi_pkg::DRV_LSB +: NDRV]         = s_reg.oc_flag;
    status1[acdspi_pkg::ST_ONE]                  = 1'b1;
    fault                                        = |{status0[22:1], status1[22:1]};
    status0[acdspi_pkg::ST_FAULT]                = fault;
    status1[acdspi_pkg::ST_FAULT]                = fault;
  end

  // committed frames queue here; applied only between frames
  assign push_valid = desel_s & ~s_reg.desel_d & (s_reg.bit_cnt == FULL_CNT);
  assign pop_ready  = desel_s;

  acdspi_fifo #(.WIDTH(FW), .DEPTH(acdspi_pkg::FIFO_DEPTH)) u_frame_fifo (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .in_valid_i  (push_valid),
    .in_ready_o  (push_ready),
    .in_data_i   (s_reg.in_sh),
    .out_valid_o (pop_valid),
    .out_ready_i (pop_ready),
    .out_data_o  (pop_data)
  );

  // shared recovery timebase from clk_i, never the serial clock
  always_comb begin
    if (s_reg.ctrl1[acdspi_pkg::FREQ_BIT]) begin
      period = REC_FAST_CYCLES;
      on_cnt = s_reg.ctrl0[acdspi_pkg::DUTY_BIT] ? ON_FAST_HI : ON_FAST_LO;
    end else begin
      period = REC_SLOW_CYCLES;
      on_cnt = s_reg.ctrl0[acdspi_pkg::DUTY_BIT] ? ON_SLOW_HI : ON_SLOW_LO;
    end
  end

  always_comb begin
    logic active;
    logic supply_off;
    logic wrap;
    logic recov;
    logic gate;
    logic [3:0] done;
    active     = 1'b0;
    supply_off = 1'b0;
    wrap       = 1'b0;
    recov      = 1'b0;
    gate       = 1'b0;
    done       = 4'h0;
    s_next     = s_reg;
    active     = s_reg.ctrl0[acdspi_pkg::ENA_BIT];
    s_next.sck_d   = sck_s;
    s_next.desel_d = desel_s;
    // a full fifo loses the frame; only a one-cycle pulse tells of it
    s_next.dropped = push_valid & ~push_ready;

    // serial engine
    if (~desel_s & s_reg.desel_d) begin
      s_next.bit_cnt    = '0;
      s_next.out_loaded = 1'b0;
      s_next.dout       = fault;
    end else if (~desel_s) begin
      if (sck_s & ~s_reg.sck_d) begin
        s_next.in_sh = {din_s, s_reg.in_sh[FW-1:1]};
        if (s_reg.bit_cnt != {acdspi_pkg::CNT_W{1'b1}}) begin
          s_next.bit_cnt = s_reg.bit_cnt + 1'b1;
        end
        if (s_reg.bit_cnt == '0) begin
          s_next.out_sh     = din_s ? status1 : status0;
          s_next.out_loaded = 1'b1;
        end
      end else if (~sck_s & s_reg.sck_d & s_reg.out_loaded) begin
        s_next.out_sh = {1'b0, s_reg.out_sh[FW-1:1]};
        s_next.dout   = s_reg.out_sh[1];
      end else if (~s_reg.out_loaded) begin
        s_next.dout = fault;
      end
    end else begin
      s_next.dout = fault;
    end

    // apply a committed frame once chip select is back high
    if (pop_valid & pop_ready) begin
      if (~pop_data[acdspi_pkg::SEL_BIT]) begin
        s_next.ctrl0 = pop_data;
      end else begin
        s_next.ctrl1 = pop_data;
      end
      if (pop_data[acdspi_pkg::CLR_BIT]) begin
        s_next.oc_flag  = '0;
        s_next.ol_flag  = '0;
        s_next.ov_flag  = 1'b0;
        s_next.uv_flag  = 1'b0;
        s_next.thoff_flag = 1'b0;
        s_next.tw_flag  = 1'b0;
        s_next.tripped  = '0;
      end
      if (~pop_data[acdspi_pkg::SEL_BIT] & ~pop_data[acdspi_pkg::ENA_BIT]) begin
        s_next.ctrl0    = acdspi_pkg::CTRL_RST;
        s_next.ctrl1    = acdspi_pkg::CTRL_RST;
        s_next.oc_flag  = '0;
        s_next.ol_flag  = '0;
        s_next.ov_flag  = 1'b0;
        s_next.uv_flag  = 1'b0;
        s_next.thoff_flag = 1'b0;
        s_next.tw_flag  = 1'b0;
        s_next.tripped  = '0;
      end
    end

    // filters run after the clear so a fresh event wins over it
    // over-current filters; a filter that has run out keeps setting while the short lasts
    for (int i = 0; i < NDRV; i++) begin
      if (short_cond[i] & active) begin
        if (s_reg.flt[i] != FLT_LAST) begin
          s_next.flt[i] = s_reg.flt[i] + 1'b1;
        end else begin
          s_next.oc_flag[i] = 1'b1;
          s_next.tripped[i] = 1'b1;
        end
      end else begin
        s_next.flt[i] = '0;
      end
    end
    // supply and temperature filters share the same 32 us count
    for (int j = 0; j < 4; j++) begin
      if (short_cond[NDRV + j] & active) begin
        if (s_reg.flt[NDRV + j] != FLT_LAST) begin
          s_next.flt[NDRV + j] = s_reg.flt[NDRV + j] + 1'b1;
        end else begin
          done[j] = 1'b1;
        end
      end else begin
        s_next.flt[NDRV + j] = '0;
      end
    end
    if (done[0]) begin
      s_next.ov_flag = 1'b1;
    end
    if (done[1]) begin
      s_next.uv_flag = 1'b1;
    end
    if (done[2]) begin
      s_next.thoff_flag = 1'b1;
    end
    if (done[3]) begin
      s_next.tw_flag = 1'b1;
    end
    for (int i = 0; i < NDRV; i++) begin
      if (diag_s[NDRV + i] & active) begin
        if (s_reg.ol_flt[i] != OLF_LAST) begin
          s_next.ol_flt[i] = s_reg.ol_flt[i] + 1'b1;
        end else begin
          s_next.ol_flag[i] = 1'b1;
        end
      end else begin
        s_next.ol_flt[i] = '0;
      end
    end

    // recovery cycling: tripped outputs re-arm at each period start
    wrap = (s_reg.per_cnt >= period - 15'h0001);
    s_next.per_cnt = wrap ? '0 : s_reg.per_cnt + 1'b1;
    // with UVOV_DIS_BIT set, latched supply flags hold the drivers off until cleared; otherwise the synchronised raw supply levels gate them
    if (s_reg.ctrl0[acdspi_pkg::UVOV_DIS_BIT]) begin
      supply_off = s_reg.ov_flag | s_reg.uv_flag;
    end else begin
      supply_off = diag_s[2*NDRV] | diag_s[2*NDRV+1];
    end
    for (int i = 0; i < NDRV; i++) begin
      recov = s_reg.ctrl1[acdspi_pkg::DRV_LSB + i];
      // re-arm at each period start; a short still present trips again at once
      if (wrap & recov) begin
        s_next.tripped[i] = s_next.tripped[i] & short_cond[i];
      end
      gate = recov & (s_reg.per_cnt < on_cnt);
      // without the recovery bit a trip holds until the flag is cleared
      s_next.drv_en[i] = active & s_reg.ctrl0[acdspi_pkg::DRV_LSB + i]
                         & ~s_reg.thoff_flag
                         & ~supply_off
                         & (~s_reg.tripped[i] | gate);
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_reg       <= '0;
      s_reg.sck_d <= 1'b0;
      // idle levels: serial clock low, chip select deselected
      s_reg.desel_d <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign device_to_host_o    = s_reg.dout;
  // enable follows the registered select, so it lags the pin by the synchroniser depth plus one cycle
  assign device_to_host_oe_o = ~s_reg.desel_d;
  assign drv_en_o            = s_reg.drv_en;
  assign current_image_sel_o = s_reg.ctrl0[acdspi_pkg::MON_LSB +: 2];
  assign active_o            = s_reg.ctrl0[acdspi_pkg::ENA_BIT];
  assign thermal_off_flag_o  = s_reg.thoff_flag;
  assign frame_dropped_o     = s_reg.dropped;
endmodule // acdspi_core

// File: hw/acdspi_fifo.sv
// small valid/ready fifo holding committed frames
// assumes both sides run on clk_i; depth is a power of two
`timescale 1ns/1ps
module acdspi_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 16
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0]   fill;
  } acdspi_fifo_t;

  acdspi_fifo_t f_reg;
  acdspi_fifo_t f_next;
  logic [WIDTH-1:0] mem [DEPTH];
  logic             push;
  logic             pop;

  assign in_ready_o  = (f_reg.fill != (AW+1)'(DEPTH));
  assign out_valid_o = (f_reg.fill != '0);
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;
  assign out_data_o  = mem[f_reg.rd];

  always_comb begin
    f_next = f_reg;
    if (push) begin
      f_next.wr = f_reg.wr + 1'b1;
    end
    if (pop) begin
      f_next.rd = f_reg.rd + 1'b1;
    end
    f_next.fill = f_reg.fill + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      f_reg <= '0;
    end else begin
      f_reg <= f_next;
    end
  end

  // storage needs no reset; only valid slots are ever read out
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[f_reg.wr] <= in_data_i;
    end
  end
endmodule // acdspi_fifo

// File: hw/acdspi_pkg.sv
// constants shared by the serial front end, its fifo and its synchroniser
// assumes a 40 MHz system clock; all timing counts derive from it
package acdspi_pkg;
  localparam int CLK_HZ        = 40_000_000;
  localparam int FRAME_BITS    = 24;
  localparam int NUM_DRV       = 17;
  localparam int FIFO_DEPTH    = 16;
  // diagnostic filter times
  localparam int DIAG_FILT_NS  = 32_000;
  localparam int DIAG_FILT_CYC = (DIAG_FILT_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int OL_FILT_US    = 1000;
  localparam int OL_FILT_CYC   = OL_FILT_US * (CLK_HZ / 1_000_000);
  // recovery cycling rate and duty
  localparam int REC_SLOW_HZ   = 1500;
  localparam int REC_FAST_HZ   = 3000;
  localparam int REC_SLOW_CYC  = CLK_HZ / REC_SLOW_HZ;
  localparam int REC_FAST_CYC  = CLK_HZ / REC_FAST_HZ;
  localparam int DUTY_LOW_PCT  = 15;
  localparam int DUTY_HIGH_PCT = 25;
  // counter widths
  localparam int CNT_W         = 5;
  localparam int FLT_W         = 11;
  localparam int OLF_W         = 16;
  localparam int PER_W         = 15;
  // input register fields
  localparam int SEL_BIT       = 0;
  localparam int DRV_LSB       = 1;
  localparam int MON_LSB       = 18;
  localparam int UVOV_DIS_BIT  = 20;
  localparam int DUTY_BIT      = 21;
  localparam int CLR_BIT       = 22;
  localparam int ENA_BIT       = 23;
  localparam int FREQ_BIT      = 21;
  // status register fields
  localparam int ST_FAULT      = 0;
  localparam int ST_TW         = 19;
  localparam int ST_THOFF      = 20;
  localparam int ST_UV         = 21;
  localparam int ST_OV         = 22;
  localparam int ST_ONE        = 23;
  // reset values
  localparam logic [23:0] CTRL_RST = 24'h000000;
endpackage

// File: hw/acdspi_sync.sv
// two-flop synchroniser for a bundle of unrelated level inputs
// assumes each bit is a slow level or a clock far below clk_i
`timescale 1ns/1ps
module acdspi_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } acdspi_sync_t;

  acdspi_sync_t s_reg;
  acdspi_sync_t s_next;

  always_comb begin
    s_next        = s_reg;
    s_next.meta   = async_i;
    s_next.stable = s_reg.meta;
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign sync_o = s_reg.stable;
endmodule // acdspi_sync

// File: verification/acdspi_core_monitor.sv
// concurrent checks on the serial front end's top ports
// assumes binding to acdspi_core; everything runs in the clk_i domain
`timescale 1ns/1ps
module acdspi_core_monitor (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        spi_clk_i,
  input wire logic        chip_select_low_i,
  input wire logic        device_to_host_o,
  input wire logic        device_to_host_oe_o,
  input wire logic        thermal_off_raw_i,
  input wire logic [16:0] drv_en_o,
  input wire logic [1:0]  current_image_sel_o,
  input wire logic        active_o,
  input wire logic        thermal_off_flag_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  logic [11:0] th_cnt_reg;

  // saturating run length of the raw thermal level, so long runs never wrap
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) th_cnt_reg <= 12'h000;
    else if (!thermal_off_raw_i) th_cnt_reg <= 12'h000;
    else if (th_cnt_reg != 12'hFFF) th_cnt_reg <= th_cnt_reg + 12'h001;
  end

  a_oe_on_select: assert property ($fell(chip_select_low_i) |-> ##[2:5] device_to_host_oe_o)
    else $error("output enable late after select");
  a_oe_off_idle: assert property (chip_select_low_i [*5] |-> !device_to_host_oe_o)
    else $error("output driven while deselected");
  a_thermal_all_off: assert property (thermal_off_flag_o [*2] |-> drv_en_o == 17'h00000)
    else $error("driver on during thermal shutdown");
  a_standby_all_off: assert property (!active_o [*2] |-> drv_en_o == 17'h00000)
    else $error("driver on in standby");
  a_drv_needs_active: assert property (drv_en_o != 17'h00000 |-> active_o || $past(active_o))
    else $error("driver on while not active");
  a_thermal_filter_min: assert property ($rose(thermal_off_flag_o) |-> th_cnt_reg >= 12'h500)
    else $error("thermal flag set before filter time");
  a_thermal_flag_sets: assert property (th_cnt_reg == 12'h514 && active_o |-> thermal_off_flag_o)
    else $error("thermal flag missing after filter time");
  a_out_steady_high: assert property (device_to_host_oe_o && $rose(spi_clk_i)
    |-> ##2 $stable(device_to_host_o) [*3])
    else $error("serial output moved in clock high phase");
  a_regs_only_idle: assert property ($changed({active_o, current_image_sel_o}) |-> chip_select_low_i)
    else $error("input register changed inside a frame");
endmodule // acdspi_core_monitor

bind acdspi_core acdspi_core_monitor u_acdspi_core_monitor (.clk_i(clk_i), .rst_i(rst_i), .spi_clk_i(spi_clk_i),
  .chip_select_low_i(chip_select_low_i), .device_to_host_o(device_to_host_o),
  .device_to_host_oe_o(device_to_host_oe_o), .thermal_off_raw_i(thermal_off_raw_i), .drv_en_o(drv_en_o),
  .current_image_sel_o(current_image_sel_o), .active_o(active_o), .thermal_off_flag_o(thermal_off_flag_o));

// File: verification/acdspi_core_tb_top.sv
// self-checking bench for the serial front end with recovery cycling
// assumes the host model drives the link; diagnostic levels are driven here
`timescale 1ns/1ps
module acdspi_core_tb_top;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        spi_clk, cs_low, mosi, dout, oe, miso, active, th_flag, f, en, dropped;
  logic        drop_seen = 1'b0;
  logic [16:0] oc_raw = 17'h00000;
  logic [16:0] ol_raw = 17'h00000;
  logic        ov_raw = 1'b0, uv_raw = 1'b0, th_raw = 1'b0, tw_raw = 1'b0;
  logic [16:0] drv_en;
  logic [1:0]  sel;
  logic [23:0] rd;
  int          mismatches = 0, cmp_count = 0, cycles = 0, hi, ed;

  // a released line shows the inverse, never a stale bit
  assign miso = oe ? dout : ~dout;

  initial forever #12.5 clk_i = ~clk_i;

  // a lost frame pulses one cycle; latch it so the late look still sees it
  always @(negedge clk_i) if (dropped !== 1'b0) drop_seen = 1'b1;

  acdspi_host_model u_acdspi_host_model (.clk_i(clk_i), .miso_i(miso), .oe_i(oe), .spi_clk_o(spi_clk),
    .chip_select_low_o(cs_low), .mosi_o(mosi));
  // shortened periods: slow 400, fast 200 cycles
  acdspi_core #(.OL_FILT_CYCLES(16'h0064), .REC_SLOW_CYCLES(15'h0190), .REC_FAST_CYCLES(15'h00C8)) u_acdspi_core (
    .clk_i(clk_i), .rst_i(rst_i), .spi_clk_i(spi_clk), .chip_select_low_i(cs_low), .host_to_device_line_i(mosi),
    .device_to_host_o(dout), .device_to_host_oe_o(oe), .overcurrent_raw_i(oc_raw), .open_load_raw_i(ol_raw),
    .overvoltage_raw_i(ov_raw), .undervoltage_raw_i(uv_raw), .thermal_off_raw_i(th_raw),
    .temp_warning_raw_i(tw_raw), .drv_en_o(drv_en), .current_image_sel_o(sel), .active_o(active),
    .thermal_off_flag_o(th_flag), .frame_dropped_o(dropped));

  task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic finish_test();
    $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 40000) begin
      mismatches++;
      finish_test();
    end
  end

  task automatic wait_clk(input int n);
    repeat (n) @(negedge clk_i);
  endtask

  task automatic wr(input logic [23:0] d);
    u_acdspi_host_model.xfer(d, 24, rd);
  endtask

  // high cycles and rising edges of driver 1 over n cycles
  task automatic measure(input int n);
    logic p;
    hi = 0;
    ed = 0;
    p = drv_en[1];
    repeat (n) begin
      @(negedge clk_i);
      hi += int'(drv_en[1]);
      ed += int'(drv_en[1] && !p);
      p = drv_en[1];
    end
  endtask

  task automatic t_basic();
    check("oe idle", oe, 1'b0);
    check("standby", active, 1'b0);
    wr(24'h800002);
    check("status0", rd, 24'h800000);
    check("active", active, 1'b1);
    check("drv", drv_en, 17'h00001);
    wr(24'h000001);
    check("status1", rd, 24'h800000);
  endtask

  task automatic t_length();
    u_acdspi_host_model.xfer(24'h8C0006, 23, rd);
    check("short sel", sel, 2'b00);
    u_acdspi_host_model.xfer(24'h8C0006, 25, rd);
    check("long drv", drv_en, 17'h00001);
    wr(24'h8C0006);
    check("sel", sel, 2'b11);
    check("drv two", drv_en, 17'h00003);
  endtask

  task automatic t_overcurrent();
    oc_raw[1] = 1'b1;
    wait_clk(1000);
    oc_raw[1] = 1'b0;
    wait_clk(20);
    check("short oc", drv_en, 17'h00003);
    oc_raw[1] = 1'b1;
    wait_clk(1300);
    oc_raw[1] = 1'b0;
    check("oc trip", drv_en, 17'h00001);
    u_acdspi_host_model.poll(f, en);
    check("fault", f, 1'b1);
    check("oe on", en, 1'b1);
    wr(24'h000001);
    check("status1 oc", rd, 24'h800005);
    wait_clk(100);
    check("latched", drv_en, 17'h00001);
    wr(24'h400001);
    check("cleared", drv_en, 17'h00003);
    u_acdspi_host_model.poll(f, en);
    check("no fault", f, 1'b0);
  endtask

  task automatic t_thermal();
    th_raw = 1'b1;
    wait_clk(1320);
    check("th flag", th_flag, 1'b1);
    th_raw = 1'b0;
    wait_clk(50);
    check("th off", drv_en, 17'h00000);
    wr(24'h400001);
    check("th clr", th_flag, 1'b0);
    check("th back", drv_en, 17'h00003);
  endtask

  task automatic t_recovery();
    wr(24'hA00006);
    wr(24'h200005);
    oc_raw[1] = 1'b1;
    wait_clk(1300);
    measure(800);
    check("duty25 fast", hi >= 180 && hi <= 220, 1'b1);
    check("rate fast", ed, 24'h000004);
    wr(24'h000005);
    measure(800);
    check("rate slow", ed, 24'h000002);
    wr(24'h800006);
    measure(800);
    check("duty15 slow", hi >= 108 && hi <= 132, 1'b1);
    wr(24'h000001);
    wait_clk(50);
    measure(800);
    check("held off", hi, 24'h000000);
    oc_raw[1] = 1'b0;
    wr(24'h400001);
    check("rec clr", drv_en, 17'h00003);
  endtask

  task automatic t_standby();
    ol_raw[0] = 1'b1;
    tw_raw = 1'b1;
    ov_raw = 1'b1;
    wait_clk(1300);
    ol_raw[0] = 1'b0;
    tw_raw = 1'b0;
    ov_raw = 1'b0;
    wr(24'h800006);
    check("st0 flags", rd, 24'hC80003);
    wr(24'h000002);
    check("stby", active, 1'b0);
    check("stby drv", drv_en, 17'h00000);
    wr(24'h800000);
    check("stby st0", rd, 24'h800000);
    check("no drop", drop_seen, 1'b0);
  endtask

  initial begin
    repeat (3) @(negedge clk_i);
    rst_i = 1'b0;
    wait_clk(4);
    t_basic();
    t_length();
    t_overcurrent();
    t_thermal();
    t_recovery();
    t_standby();
    finish_test();
  end
endmodule // acdspi_core_tb_top

// File: verification/acdspi_host_model.sv
// host-side serial master model, clock idle low, lsb first
// assumes one caller at a time; all pins change at clk_i falling edges
`timescale 1ns/1ps
module acdspi_host_model (
  input  wire logic clk_i,
  input  wire logic miso_i,
  input  wire logic oe_i,
  output logic      spi_clk_o,
  output logic      chip_select_low_o,
  output logic      mosi_o
);
  initial begin
    spi_clk_o = 1'b0;
    chip_select_low_o = 1'b1;
    mosi_o = 1'b0;
  end

  // half of a 200 ns serial period
  task automatic half();
    repeat (4) @(negedge clk_i);
  endtask

  // nbits other than 24 are sent only to see the frame refused
  task automatic xfer(input logic [23:0] wd, input int nbits, output logic [23:0] rd);
    rd = 24'h000000;
    @(negedge clk_i);
    chip_select_low_o = 1'b0;
    for (int i = 0; i < nbits; i++) begin
      mosi_o = wd[i % 24];
      half();
      spi_clk_o = 1'b1;
      half();
      // sampled late in the high phase: the answer lags by a few clocks
      if (i < 24) rd[i] = miso_i;
      spi_clk_o = 1'b0;
    end
    half();
    chip_select_low_o = 1'b1;
    mosi_o = ~mosi_o;
    repeat (12) @(negedge clk_i);
  endtask

  // select without any clock: only the fault summary shows
  task automatic poll(output logic f, output logic en);
    @(negedge clk_i);
    chip_select_low_o = 1'b0;
    repeat (6) @(negedge clk_i);
    f = miso_i;
    en = oe_i;
    chip_select_low_o = 1'b1;
    repeat (8) @(negedge clk_i);
  endtask
endmodule // acdspi_host_model
